//--- include/bootlock_regs.svh
`ifndef BOOTLOCK_REGS_SVH
`define BOOTLOCK_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define REG_LOCK        8'h00
`define REG_FUSE        8'h04
`define REG_STATUS      8'h08
`define REG_VECTOR      8'h0C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LK_GEN_LO       0
`define LK_GEN_HI       1
`define LK_APP_LO       2
`define LK_APP_HI       3
`define LK_BOOT_LO      4
`define LK_BOOT_HI      5
`define ST_WR_BLK       0
`define ST_RD_BLK       1
`define ST_APP_STORE    2
`define FUSE_RST        0
`define FUSE_SZ_LO      1

// ---------------------------------------------------------------
// Reset values and section boundaries (word addresses)
// ---------------------------------------------------------------
`define LOCK_RESET      6'h00
`define LOCK_ERASED     6'h3F
`define STATUS_RESET    3'h0
`define APP_RESET_VEC   15'h0000
`define BOOT_START_0    15'h7000
`define BOOT_START_1    15'h7800
`define BOOT_START_2    15'h7C00
`define BOOT_START_3    15'h7E00

// ---------------------------------------------------------------
// Timing counts and bus answers
// ---------------------------------------------------------------
`define RESTORE_CYC     2'h3
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

//--- include/bootlock_pkg.sv
`include "bootlock_regs.svh"

package bootlock_pkg;

	typedef enum logic [1:0] {
		ACC_READ  = 2'b00,
		ACC_WRITE = 2'b01,
		ACC_LOCK  = 2'b10,
		ACC_NONE  = 2'b11
	} acc_kind_t;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_t;

	// First word of the boot loader section for a size setting
	function automatic logic [14:0] boot_start(input logic [1:0] sz);
		logic [14:0] s;
		unique case (sz)
			2'b00: s = `BOOT_START_0;
			2'b01: s = `BOOT_START_1;
			2'b10: s = `BOOT_START_2;
			2'b11: s = `BOOT_START_3;
		endcase
		return s;
	endfunction

	function automatic logic in_boot(input logic [14:0] addr, input logic [1:0] sz);
		return addr >= boot_start(sz);
	endfunction

endpackage

//--- include/prot_if.sv
interface prot_if;
	import bootlock_pkg::*;

	logic        fetch_boot;
	logic        target_boot;
	logic        ivec_boot;
	logic [5:0]  locks;
	logic        wr_allow;
	logic        rd_allow;
	logic        lock_allow;
	logic        irq_mask;

	modport decider (
		input  fetch_boot, target_boot, ivec_boot, locks,
		output wr_allow, rd_allow, lock_allow, irq_mask
	);

	modport owner (
		output fetch_boot, target_boot, ivec_boot, locks,
		input  wr_allow, rd_allow, lock_allow, irq_mask
	);

endinterface

//--- core/lock_decider.sv
`include "bootlock_regs.svh"

module lock_decider
	import bootlock_pkg::*;
(
	prot_if.decider p
);

	logic app_lo;
	logic app_hi;
	logic boot_lo;
	logic boot_hi;

	// 1 = unprogrammed, 0 = programmed
	assign app_lo  = p.locks[`LK_APP_LO];
	assign app_hi  = p.locks[`LK_APP_HI];
	assign boot_lo = p.locks[`LK_BOOT_LO];
	assign boot_hi = p.locks[`LK_BOOT_HI];

	// ---------------------------------------------------------------
	// Decision, purely combinational
	// ---------------------------------------------------------------
	// General lock bits are left out on purpose
	always_comb begin
		// Stores only act from the boot loader section
		if (p.target_boot)
			p.wr_allow = p.fetch_boot & boot_lo;
		else
			p.wr_allow = p.fetch_boot & app_lo;
		// Cross-section reads fail when the high bit is programmed
		p.rd_allow = !(p.fetch_boot && !p.target_boot && !app_hi)
			&& !(!p.fetch_boot && p.target_boot && !boot_hi);
	end

	assign p.lock_allow = p.fetch_boot;

	assign p.irq_mask = (!p.fetch_boot && p.ivec_boot && !app_hi)
		|| (p.fetch_boot && !p.ivec_boot && !boot_hi);

endmodule

//--- core/boot_lock_protection_checker.sv
// Overview of operation
// - Separate lock pairs govern the application and the boot loader sections.
// - Locks only move toward programmed; chip erase and the restore load after reset alone unprogram them.
// - General write lock has no say over self-program stores.
// - General read/write lock restricts neither program loads nor stores.
// - Every lock and fuse bit: 1 is unprogrammed, 0 programmed.
// - Application mode 1 allows every store and load to it.
// - Application mode 2 blocks stores into it, allows loads.
// - Application mode 3 blocks stores and loads from the boot section.
// - Application mode 4 allows stores, blocks loads from the boot section.
// - Application modes 3/4 with boot vectors mask interrupts in application.
// - Boot mode 1 allows every store and load to the boot section.
// - Boot mode 2 blocks stores into the boot section, allows loads.
// - Boot mode 3 blocks stores and loads from the application.
// - Boot mode 4 allows stores, blocks loads from the application.
// - Boot modes 3/4 with application vectors mask interrupts in boot.
// - Reset vector is 0x0000 if fuse unprogrammed, else boot start.
// - The processor cannot alter any fuse; only programming pins can.
// - Size fuse sets the section boundary for fetch and target addresses.
// - Stores program only when executed from the boot loader section.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`include "bootlock_regs.svh"

module boot_lock_protection_checker
	import bootlock_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// AXI4-Lite write channels
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Core program memory accesses
	input  wire logic        acc_valid,
	input  wire acc_kind_t   acc_kind,
	input  wire logic [14:0] fetch_addr,
	input  wire logic [14:0] target_addr,
	input  wire logic [5:0]  acc_lock_data,
	input  wire logic        ivec_in_boot,
	output logic             flash_wr_en,
	output logic             flash_rd_en,
	output logic             rd_blocked,
	output logic             irq_mask,
	// Fuses and programming interface pins
	input  wire logic        boot_reset_select_fuse,
	input  wire logic [1:0]  boot_size_fuse,
	input  wire logic        prog_lock_req,
	input  wire logic [5:0]  prog_lock_data,
	input  wire logic        prog_erase_req,
	input  wire logic [5:0]  nv_lock,
	// Lock and vector state
	output logic [14:0]      reset_vector,
	output logic [5:0]       lock_state
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic        rst_fuse_s1_q;
	logic        rst_fuse_s2_q;
	logic [1:0]  size_s1_q;
	logic [1:0]  size_s2_q;
	logic        plock_s1_q;
	logic        plock_s2_q;
	logic        plock_s3_q;
	logic [5:0]  pdata_s1_q;
	logic [5:0]  pdata_s2_q;
	logic        erase_s1_q;
	logic        erase_s2_q;
	logic        erase_s3_q;
	logic [5:0]  nv_s1_q;
	logic [5:0]  nv_s2_q;

	// Fuses arrive only from pins; nothing on the bus reaches them
	always_ff @(posedge clk) begin
		rst_fuse_s1_q <= boot_reset_select_fuse;
		rst_fuse_s2_q <= rst_fuse_s1_q;
		size_s1_q     <= boot_size_fuse;
		size_s2_q     <= size_s1_q;
		plock_s1_q    <= prog_lock_req;
		plock_s2_q    <= plock_s1_q;
		plock_s3_q    <= plock_s2_q;
		pdata_s1_q    <= prog_lock_data;
		pdata_s2_q    <= pdata_s1_q;
		erase_s1_q    <= prog_erase_req;
		erase_s2_q    <= erase_s1_q;
		erase_s3_q    <= erase_s2_q;
		nv_s1_q       <= nv_lock;
		nv_s2_q       <= nv_s1_q;
	end

	logic prog_lock_pulse;
	logic prog_erase_pulse;

	assign prog_lock_pulse  = plock_s2_q & ~plock_s3_q;
	assign prog_erase_pulse = erase_s2_q & ~erase_s3_q;

	// ---------------------------------------------------------------
	// Section classification and decision
	// ---------------------------------------------------------------
	prot_if pif ();

	logic [5:0] lock_q;
	logic [5:0] lock_d;

	assign pif.fetch_boot  = in_boot(fetch_addr, size_s2_q);
	assign pif.target_boot = in_boot(target_addr, size_s2_q);
	assign pif.ivec_boot   = ivec_in_boot;
	assign pif.locks       = lock_q;

	lock_decider u_decider (
		.p (pif.decider)
	);

	logic is_store;
	logic is_load;
	logic is_lock_set;

	assign is_store    = acc_valid && (acc_kind == ACC_WRITE);
	assign is_load     = acc_valid && (acc_kind == ACC_READ);
	assign is_lock_set = acc_valid && (acc_kind == ACC_LOCK) && pif.lock_allow;

	// Blocked stores never reach the array
	assign flash_wr_en = is_store && pif.wr_allow;
	assign flash_rd_en = is_load && pif.rd_allow;
	assign rd_blocked  = is_load && !pif.rd_allow;
	assign irq_mask    = pif.irq_mask;

	// ---------------------------------------------------------------
	// Lock bits
	// ---------------------------------------------------------------
	logic [1:0] restore_cnt_q;
	logic       restoring;
	logic       bus_lock_wr;
	logic [5:0] bus_lock_val;

	assign restoring = (restore_cnt_q != `RESTORE_CYC);

	// Waits for the nonvolatile copy to pass the synchroniser
	always_ff @(posedge clk) begin
		if (reset)
			restore_cnt_q <= 2'h0;
		else if (restoring)
			restore_cnt_q <= restore_cnt_q + 2'h1;
	end

	// Each source may only clear bits; only erase and the restore load set them
	always_comb begin
		lock_d = lock_q;
		if (restore_cnt_q == 2'h2)
			lock_d = nv_s2_q;
		if (bus_lock_wr)
			lock_d = lock_d & bus_lock_val;
		if (is_lock_set)
			lock_d = lock_d & acc_lock_data;
		if (prog_lock_pulse)
			lock_d = lock_d & pdata_s2_q;
		if (prog_erase_pulse)
			lock_d = `LOCK_ERASED;
	end

	// Three independent pairs share one holding register
	always_ff @(posedge clk) begin
		if (reset)
			lock_q <= `LOCK_RESET;
		else
			lock_q <= lock_d;
	end

	assign lock_state = lock_q;

	// ---------------------------------------------------------------
	// Reset vector
	// ---------------------------------------------------------------
	logic [14:0] reset_vec_q;

	always_ff @(posedge clk) begin
		if (reset)
			reset_vec_q <= `APP_RESET_VEC;
		else if (rst_fuse_s2_q)
			reset_vec_q <= `APP_RESET_VEC;
		else
			reset_vec_q <= boot_start(size_s2_q);
	end

	assign reset_vector = reset_vec_q;

	// ---------------------------------------------------------------
	// Sticky status
	// ---------------------------------------------------------------
	logic [2:0] status_q;
	logic [2:0] status_set;
	logic [2:0] status_clr;

	assign status_set[`ST_WR_BLK]    = is_store && !pif.wr_allow;
	assign status_set[`ST_RD_BLK]    = rd_blocked;
	assign status_set[`ST_APP_STORE] = acc_valid && !pif.fetch_boot
		&& (acc_kind == ACC_WRITE || acc_kind == ACC_LOCK);

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset)
			status_q <= `STATUS_RESET;
		else
			status_q <= (status_q & ~status_clr) | status_set;
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write path
	// ---------------------------------------------------------------
	logic        aw_got_q;
	logic        w_got_q;
	logic [7:0]  waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        wr_fire;

	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready  = !w_got_q && !bvalid_q;
	assign wr_fire       = aw_got_q && w_got_q && !bvalid_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_got_q <= 1'b0;
			waddr_q  <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_q <= 1'b1;
			waddr_q  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_got_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_got_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_got_q <= 1'b0;
		end
	end

	logic wr_mapped;

	assign wr_mapped = (waddr_q[7:2] == `REG_LOCK >> 2)
		|| (waddr_q[7:2] == `REG_FUSE >> 2)
		|| (waddr_q[7:2] == `REG_STATUS >> 2)
		|| (waddr_q[7:2] == `REG_VECTOR >> 2);

	// Fuse and vector words ignore writes
	assign bus_lock_wr  = wr_fire && wstrb_q[0]
		&& (waddr_q[7:2] == `REG_LOCK >> 2) && !restoring;
	assign bus_lock_val = wdata_q[5:0];
	assign status_clr   = (wr_fire && wstrb_q[0]
		&& (waddr_q[7:2] == `REG_STATUS >> 2)) ? wdata_q[2:0] : 3'h0;

	always_ff @(posedge clk) begin
		if (reset) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// ---------------------------------------------------------------
	// AXI4-Lite read path
	// ---------------------------------------------------------------
	rd_state_t   rd_state_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] rd_word;
	logic        rd_mapped;

	always_comb begin
		rd_word   = 32'h0000_0000;
		rd_mapped = 1'b1;
		unique case (s_axi_araddr[7:2])
			`REG_LOCK >> 2:
				rd_word[5:0] = lock_q;
			`REG_FUSE >> 2: begin
				rd_word[`FUSE_RST] = rst_fuse_s2_q;
				rd_word[`FUSE_SZ_LO +: 2] = size_s2_q;
			end
			`REG_STATUS >> 2:
				rd_word[2:0] = status_q;
			`REG_VECTOR >> 2:
				rd_word[14:0] = reset_vec_q;
			default:
				rd_mapped = 1'b0;
		endcase
	end

	assign s_axi_arready = (rd_state_q == RD_IDLE);

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_state_q <= RD_IDLE;
			rdata_q    <= 32'h0000_0000;
			rresp_q    <= `RESP_OKAY;
		end else begin
			unique case (rd_state_q)
				RD_IDLE: begin
					if (s_axi_arvalid) begin
						rd_state_q <= RD_DATA;
						rdata_q    <= rd_word;
						rresp_q    <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
					end
				end
				RD_DATA: begin
					if (s_axi_rready)
						rd_state_q <= RD_IDLE;
				end
			endcase
		end
	end

	assign s_axi_rvalid = (rd_state_q == RD_DATA);
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

endmodule

//--- dv/bootlock_asserts.sv
module bootlock_asserts
	import bootlock_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Core access
	input wire logic        acc_valid,
	input wire acc_kind_t   acc_kind,
	input wire logic [14:0] fetch_addr,
	input wire logic [14:0] target_addr,
	input wire logic        ivec_in_boot,
	input wire logic        flash_wr_en,
	input wire logic        flash_rd_en,
	input wire logic        rd_blocked,
	input wire logic        irq_mask,
	// Fuses and lock state
	input wire logic        boot_reset_select_fuse,
	input wire logic [1:0]  boot_size_fuse,
	input wire logic        prog_erase_req,
	input wire logic [14:0] reset_vector,
	input wire logic [5:0]  lock_state
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	logic [11:0] hist_q;
	logic [2:0]  run_q;
	logic [14:0] bstart;
	logic        fb, tb, ok, wr, rd;

	// Fuse pins must have settled before decisions are judged
	always_ff @(posedge clk) begin
		hist_q <= {hist_q[8:0], boot_reset_select_fuse, boot_size_fuse};
	end
	always_ff @(posedge clk) begin
		if (reset)
			run_q <= 3'h0;
		else if (run_q != 3'h7)
			run_q <= run_q + 3'h1;
	end
	assign bstart = 15'(16'h8000 - (16'h1000 >> boot_size_fuse));
	assign ok = run_q == 3'h7 && hist_q == {4{boot_reset_select_fuse, boot_size_fuse}};
	assign fb = fetch_addr >= bstart;
	assign tb = target_addr >= bstart;
	assign wr = ok && acc_valid && acc_kind == ACC_WRITE;
	assign rd = ok && acc_valid && acc_kind == ACC_READ;

	sequence erase_rise;
		!prog_erase_req ##1 prog_erase_req;
	endsequence
	sequence erased_soon;
		##[2:6] lock_state == 6'h3F;
	endsequence

	a_store_from_app: assert property (wr && !fb |-> !flash_wr_en)
		else $error("store from application section was let through");
	a_app_store_lock: assert property (wr && fb && !tb |-> flash_wr_en == lock_state[2])
		else $error("application store permission wrong");
	a_boot_store_lock: assert property (wr && fb && tb |-> flash_wr_en == lock_state[4])
		else $error("boot section store permission wrong");
	a_app_load_lock: assert property (rd && fb && !tb |-> rd_blocked != lock_state[3] && flash_rd_en == lock_state[3])
		else $error("application load from boot code decided wrongly");
	a_boot_load_lock: assert property (rd && !fb && tb |-> rd_blocked != lock_state[5] && flash_rd_en == lock_state[5])
		else $error("boot section load from application decided wrongly");
	a_own_load_free: assert property (rd && fb == tb |-> flash_rd_en && !rd_blocked)
		else $error("load within own section refused");
	a_irq_masking: assert property (ok && acc_valid |-> irq_mask == ((!fb && ivec_in_boot && !lock_state[3]) || (fb && !ivec_in_boot && !lock_state[5])))
		else $error("interrupt mask wrong");
	a_reset_vector: assert property (ok |-> reset_vector == (boot_reset_select_fuse ? 15'h0000 : bstart))
		else $error("reset vector wrong");
	a_erase_unlocks: assert property (erase_rise |-> erased_soon)
		else $error("erase did not unprogram locks");
	a_locks_only_program: assert property (run_q == 3'h7 && |(lock_state & ~$past(lock_state)) |-> $past(prog_erase_req, 3))
		else $error("lock bit unprogrammed without erase");
endmodule

bind boot_lock_protection_checker bootlock_asserts chk (.*);

//--- dv/core_model.sv
module core_model
	import bootlock_pkg::*;
(
	// Clock
	input  wire logic   clk,
	// Program memory access
	output logic        acc_valid,
	output acc_kind_t   acc_kind,
	output logic [14:0] fetch_addr,
	output logic [14:0] target_addr,
	output logic [5:0]  acc_lock_data,
	output logic        ivec_in_boot
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		acc_valid = 1'h0;
		acc_kind = ACC_NONE;
		fetch_addr = 15'h0;
		target_addr = 15'h0;
		acc_lock_data = 6'h3F;
		ivec_in_boot = 1'h0;
	end

	// One access, held until the next issue or rest
	task automatic issue(input acc_kind_t k, input logic [14:0] f, t, input logic [5:0] d,
			input logic iv);
		@(posedge clk);
		acc_valid <= 1'h1;
		acc_kind <= k;
		fetch_addr <= f;
		target_addr <= t;
		acc_lock_data <= d;
		ivec_in_boot <= iv;
	endtask

	// Target and lock data lines turn over so stale values never look live
	task automatic rest();
		@(posedge clk);
		acc_valid <= 1'h0;
		acc_kind <= ACC_NONE;
		target_addr <= ~target_addr;
		acc_lock_data <= ~acc_lock_data;
	endtask
endmodule

//--- dv/tb_top.sv
`include "bootlock_regs.svh"

module tb_top
	import bootlock_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, reset, boot_reset_select_fuse, prog_lock_req, prog_erase_req;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, rv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, boot_size_fuse, rs;
	logic        acc_valid, ivec_in_boot, flash_wr_en, flash_rd_en, rd_blocked, irq_mask;
	acc_kind_t   acc_kind, k;
	logic [14:0] fetch_addr, target_addr, reset_vector, f, t;
	logic [5:0]  acc_lock_data, prog_lock_data, nv_lock, lock_state, lk;
	int          mismatches, checked;

	boot_lock_protection_checker uut (.*);
	core_model core (.*);

	always #20 clk = ~clk;

	// --------------------------------
	// Helpers
	// --------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [14:0] bound(input logic [1:0] sz);
		return 15'(16'h8000 - (16'h1000 >> sz));
	endfunction

	// Expected store ok, load ok, load refused, interrupts masked
	function automatic logic [3:0] judge(input acc_kind_t a, input logic [14:0] fa, ta,
			input logic iv, input logic [5:0] l);
		logic fb, tb, rb;
		fb = fa >= bound(boot_size_fuse);
		tb = ta >= bound(boot_size_fuse);
		rb = (fb && !tb && !l[3]) || (!fb && tb && !l[5]);
		return {a == ACC_WRITE && fb && (tb ? l[4] : l[2]), a == ACC_READ && !rb,
			a == ACC_READ && rb, (!fb && iv && !l[3]) || (fb && !iv && !l[5])};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (e !== g) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic restart(input logic [5:0] nv, input logic [2:0] fz);
		@(posedge clk);
		reset <= 1'h1;
		nv_lock <= nv;
		{boot_reset_select_fuse, boot_size_fuse} <= fz;
		repeat (4) @(posedge clk);
		chk("locks in reset", 32'h0, lock_state);
		reset <= 1'h0;
		repeat (8) @(posedge clk);
	endtask

	// One register transfer; handshakes judged on settled values
	task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic [1:0] r);
		int n;
		logic ta, tw, tr, g;
		@(posedge clk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= wd;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
		end
		n = 0;
		g = 1'h0;
		while (!g && n < 40) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tr = s_axi_arvalid && s_axi_arready;
			g = w ? s_axi_bvalid : s_axi_rvalid;
			rd = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'h0;
			if (tw)
				s_axi_wvalid <= 1'h0;
			if (tr)
				s_axi_arvalid <= 1'h0;
			n++;
		end
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
		chk("bus answer", 32'h1, 32'(g));
	endtask

	task automatic access(input acc_kind_t a, input logic [14:0] fa, ta, input logic iv,
			input logic [3:0] e);
		core.issue(a, fa, ta, 6'h3F, iv);
		@(negedge clk);
		chk("access outcome", e, {flash_wr_en, flash_rd_en, rd_blocked, irq_mask});
	endtask

	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		{clk, reset, seed} = {2'h1, 32'hb568_b75b};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_wstrb = 4'hF;
		{boot_reset_select_fuse, boot_size_fuse, prog_lock_req, prog_erase_req} = 5'h1C;
		{prog_lock_data, nv_lock} = 12'hFFF;
		for (int i = 0; i < 24; i++) begin
			rv = xs();
			lk = rv[5:0];
			restart(lk, rv[8:6]);
			chk("restored locks", lk, lock_state);
			chk("reset vector", rv[8] ? 15'h0 : bound(rv[7:6]), reset_vector);
			for (int j = 0; j < 16; j++) begin
				rv = xs();
				k = rv[1:0] == 2'h3 ? ACC_NONE : (rv[0] ? ACC_WRITE : ACC_READ);
				f = rv[2] ? rv[30:16] : bound(boot_size_fuse) - 15'h0008 + rv[6:3];
				t = rv[9] ? rv[24:10] : bound(boot_size_fuse) - 15'h0008 + rv[13:10];
				access(k, f, t, rv[31], judge(k, f, t, rv[31], lk));
			end
			core.rest();
		end
		$display("random access test done");
		restart(6'h3F, 3'h3);
		axi(1'h0, `REG_FUSE, 32'h0, rv, rs);
		chk("fuse register", 32'h6, rv);
		axi(1'h1, `REG_FUSE, 32'h0, rv, rs);
		axi(1'h0, `REG_FUSE, 32'h0, rv, rs);
		chk("fuse after write", 32'h6, rv);
		axi(1'h1, `REG_VECTOR, 32'h7FFF, rv, rs);
		axi(1'h0, `REG_VECTOR, 32'h0, rv, rs);
		chk("vector register", 32'h0000_7E00, rv);
		axi(1'h1, 8'h10, 32'h0, rv, rs);
		chk("unmapped write", `RESP_SLVERR, rs);
		axi(1'h0, 8'h10, 32'h0, rv, rs);
		chk("unmapped read", `RESP_SLVERR, rs);
		$display("register test done");
		access(ACC_WRITE, 15'h0100, 15'h0200, 1'h0, 4'h0);
		core.issue(ACC_LOCK, 15'h0100, 15'h0, 6'h00, 1'h0);
		core.issue(ACC_LOCK, 15'h7E00, 15'h0, 6'h3B, 1'h0);
		core.rest();
		@(negedge clk);
		chk("lock set by store", 32'h3B, lock_state);
		access(ACC_WRITE, 15'h7E00, 15'h0200, 1'h0, 4'h0);
		access(ACC_READ, 15'h7E00, 15'h0200, 1'h0, 4'h4);
		core.rest();
		axi(1'h0, `REG_STATUS, 32'h0, rv, rs);
		chk("status flags", 32'h5, rv);
		axi(1'h1, `REG_STATUS, 32'h5, rv, rs);
		axi(1'h0, `REG_STATUS, 32'h0, rv, rs);
		chk("status cleared", 32'h0, rv);
		axi(1'h1, `REG_LOCK, 32'h37, rv, rs);
		axi(1'h0, `REG_LOCK, 32'h0, rv, rs);
		chk("lock after bus write", 32'h33, rv);
		access(ACC_READ, 15'h7E00, 15'h0200, 1'h0, 4'h2);
		core.rest();
		axi(1'h0, `REG_STATUS, 32'h0, rv, rs);
		chk("load blocked flag", 32'h2, rv);
		prog_lock_data <= 6'h2F;
		repeat (4) @(posedge clk);
		prog_lock_req <= 1'h1;
		repeat (6) @(posedge clk);
		prog_lock_req <= 1'h0;
		repeat (6) @(posedge clk);
		chk("lock after pin set", 32'h23, lock_state);
		prog_erase_req <= 1'h1;
		repeat (6) @(posedge clk);
		prog_erase_req <= 1'h0;
		repeat (6) @(posedge clk);
		chk("lock after erase", 32'h3F, lock_state);
		$display("lock test done");
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("[FAIL] watchdog expected finish seen timeout");
		complete_run();
	end
endmodule
